// ---- image_pipe_defs.svh ----
// Register offsets, field positions, reset values and widths of the image pipe event and shadow control
`ifndef IMAGE_PIPE_DEFS_SVH
`define IMAGE_PIPE_DEFS_SVH

// Immediate-effect registers of the pipe (byte offsets, one word each)
`define OFS_PIPE_MODE      8'h00
`define OFS_DATA_PATH      8'h04
`define OFS_CPU_GATE       8'h08
`define OFS_SENSOR_GATE    8'h0c
`define OFS_MEMORY_GATE    8'h10
`define OFS_TBL_MODE       8'h14
`define OFS_TBL_ADDR       8'h18
`define OFS_TBL_WDATA      8'h1c
`define OFS_TBL_RDATA      8'h20
`define OFS_EVENT_ENABLE   8'h24
`define OFS_RESIZER_MODE   8'h28
`define OFS_HIST_MODE      8'h2c
`define OFS_HIST_SOURCE    8'h30
// Shadowed registers
`define OFS_RSZ_A_INTERVAL 8'h34
`define OFS_RSZ_B_INTERVAL 8'h38
`define OFS_SHADOW_BASE    8'h3c
// Read-only status registers
`define OFS_RSZ_A_PHASE    8'h50
`define OFS_RSZ_A_LINES    8'h54
`define OFS_RSZ_A_PTR      8'h58
`define OFS_RSZ_B_PHASE    8'h5c
`define OFS_RSZ_B_LINES    8'h60
`define OFS_RSZ_B_PTR      8'h64
`define OFS_OVERHEAD       8'h68

// Field positions
`define BIT_PIPE_ENABLE    0
`define BIT_PIPE_CONT      1
`define BIT_RSZ_DIVIDE     2
`define BIT_CHROMA_1331    0

// Event vector positions
`define EV_FRAME_DONE      0
`define EV_MEM_WRITE_DONE  1
`define EV_RSZ_A_INTERVAL  2
`define EV_RSZ_B_INTERVAL  3
`define EV_PIPE_STOPPED    4
`define EV_UPDATE_READY    5
`define NUM_EVENTS         6

// Overhead figures per stage
`define OVH_NF_PIX         4'h2
`define OVH_CFA_PIX        4'h2
`define OVH_CHROMA_PIX     4'h1
`define OVH_CHROMA_1331    4'h2
`define OVH_EE_PIX         4'h3
`define OVH_NF_LINE        4'h2
`define OVH_CFA_LINE       4'h2
`define OVH_EE_LINE        4'h3
`define OVH_RSZ_LINE_BOT   4'h1

// Reset values
`define RST_EVENT_ENABLE   6'h00
`define RST_INTERVAL       16'h0010

// Host local registers
`define HOST_DEV_WINDOW    8
`define OFS_HOST_STATUS    8'h00
`define OFS_HOST_DEF_ADDR  8'h04
`define OFS_HOST_DEF_DATA  8'h08
`define OFS_HOST_DEF_STATE 8'h0c

`endif

// ---- image_pipe_event_shadow_ctrl.sv ----
// Image pipe event generation, resizer status and shadow register control
//
// Operation
// - Six distinct event outputs to host
// - Frame done on flush or histogram done
// - Memory-write-done event on write completion
// - Per-resizer interval event from own register
// - Update-ready event when shadows may change
// - Each event gated by its enable bit
// - Status holds phase of last line
// - Status holds output line count of pass
// - Status holds current output buffer line
// - Immediate registers act at once, write idle
// - Immediate group: mode, path, gates, tables, enables, resizer mode, histogram mode and source
// - Shadowed values apply at next frame start
// - Shadow reads return latest written value
// - Early shadow writes may hit either frame
// - All other registers are shadowed
// - Host changes shadows after update-ready event
// - Noise filter, interpolation: two pixels, lines
// - Chroma downsampler: one pixel, two if 1331
// - Edge enhancer: three pixels and lines
// - Resizer: one bottom line, buffer delays
// - Division mode masks block boundary overhead
// - Host provides overlap per ratio formula
// - Disable latches at end of frame
//
// Local design decisions: the placing of the registers and the plain strobed port.
`timescale 1ns/10ps
`include "image_pipe_defs.svh"
module image_pipe_event_shadow_ctrl
  import image_pipe_pkg::*;
#(
  parameter int NUM_SHADOW = 4,      // Generic shadowed words: enables, width, height, pointer base
  parameter int CNT_W      = 16      // Width of line counters and sizes
) (
  input  wire logic               ref_clk,
  input  wire logic               rst_n,
  input  wire logic               clkEn,
  image_pipe_if.device            link,
  input  wire logic               frameStart,
  input  wire logic               frameEnd,
  input  wire logic               pipeFlushed,
  input  wire logic               histDone,
  input  wire logic               memWriteDone,
  input  wire logic [1:0]         rszLineDone,
  input  wire logic [1:0]         rszPassDone,
  input  wire logic [CNT_W-1:0]   rszPhaseA,
  input  wire logic [CNT_W-1:0]   rszPhaseB,
  input  wire logic [CNT_W-1:0]   pixCol,
  input  wire logic [CNT_W-1:0]   lineRow,
  input  wire logic [31:0]        tblRdata,
  output logic                    pipeRunning,
  output logic                    boundaryMask,
  output logic [31:0]             pipeMode,
  output logic [31:0]             dataPath,
  output logic [2:0]              clockGates,
  output logic [31:0]             tblMode,
  output logic [31:0]             tblAddr,
  output logic [31:0]             tblWdata,
  output logic                    tblWrStrobe,
  output logic [31:0]             resizerMode,
  output logic [31:0]             histMode,
  output logic [31:0]             histSource,
  output logic [31:0]             activeShadow [NUM_SHADOW]
);

  // Pending (written) and active copies of shadowed words
  logic [31:0]      pendShadow [NUM_SHADOW];   // Last value software wrote
  logic [CNT_W-1:0] pendInterval [2];          // Pending resizer intervals
  logic [CNT_W-1:0] actInterval [2];           // Intervals in use this frame
  logic [5:0]       eventEnable;               // Per-event gate
  logic [5:0]       eventReg;                  // Registered event pulses
  logic             startSeen;                 // Frame start while running, one cycle ago
  logic [CNT_W-1:0] lineCnt [2];               // Lines in current pass
  logic [CNT_W-1:0] intervalCnt [2];           // Lines since last interval event
  logic [CNT_W-1:0] lastPhase [2];             // Phase of last produced line
  logic [CNT_W-1:0] lineTotal [2];             // Lines of previous pass
  logic [CNT_W-1:0] linePtr [2];               // Current output buffer line

  // Address decode for the register link
  wire wrPipeMode  = link.regWr && link.regAddr == `OFS_PIPE_MODE;
  wire wrDataPath  = link.regWr && link.regAddr == `OFS_DATA_PATH;
  wire wrTblMode   = link.regWr && link.regAddr == `OFS_TBL_MODE;
  wire wrTblAddr   = link.regWr && link.regAddr == `OFS_TBL_ADDR;
  wire wrTblWdata  = link.regWr && link.regAddr == `OFS_TBL_WDATA;
  wire wrEventEn   = link.regWr && link.regAddr == `OFS_EVENT_ENABLE;
  wire wrRszMode   = link.regWr && link.regAddr == `OFS_RESIZER_MODE;
  wire wrHistMode  = link.regWr && link.regAddr == `OFS_HIST_MODE;
  wire wrHistSrc   = link.regWr && link.regAddr == `OFS_HIST_SOURCE;
  wire [2:0] wrGate = {link.regWr && link.regAddr == `OFS_MEMORY_GATE,
                       link.regWr && link.regAddr == `OFS_SENSOR_GATE,
                       link.regWr && link.regAddr == `OFS_CPU_GATE};

  // Overhead sums; the chroma stage widens only in centring mode
  wire [3:0] chromaPix = activeShadow[0][`BIT_CHROMA_1331] ? `OVH_CHROMA_1331 : `OVH_CHROMA_PIX;
  wire [3:0] latOvh    = `OVH_NF_PIX + `OVH_CFA_PIX + chromaPix + `OVH_EE_PIX;
  wire [3:0] topOvh    = `OVH_NF_LINE + `OVH_CFA_LINE + `OVH_EE_LINE;
  wire [3:0] botOvh    = topOvh + `OVH_RSZ_LINE_BOT;
  wire [CNT_W-1:0] blkWidth  = activeShadow[1][CNT_W-1:0];
  wire [CNT_W-1:0] blkHeight = activeShadow[2][CNT_W-1:0];
  wire [CNT_W-1:0] latW = {{(CNT_W-4){1'b0}}, latOvh};
  wire [CNT_W-1:0] topW = {{(CNT_W-4){1'b0}}, topOvh};
  wire [CNT_W-1:0] botW = {{(CNT_W-4){1'b0}}, botOvh};
  wire inOverhead = pixCol < latW || pixCol >= blkWidth - latW ||
                    lineRow < topW || lineRow >= blkHeight - botW;
  wire next_boundaryMask = resizerMode[`BIT_RSZ_DIVIDE] && inOverhead;

  // Raw event causes before the enable gate
  wire [5:0] rawEvent;
  assign rawEvent[`EV_FRAME_DONE]     = pipeFlushed | histDone;
  assign rawEvent[`EV_MEM_WRITE_DONE] = memWriteDone;
  // Stop event follows the run flag down at any frame end, one-shot frames included
  assign rawEvent[`EV_PIPE_STOPPED]   = pipeRunning && frameEnd &&
                                        !(pipeMode[`BIT_PIPE_ENABLE] && pipeMode[`BIT_PIPE_CONT]);
  assign rawEvent[`EV_UPDATE_READY]   = startSeen;
  assign link.events = eventReg;

  // Read mux; shadows answer with what was written, not what is active
  word_t rdMux;
  always_comb begin
    rdMux = 32'h0000_0000;
    unique case (link.regAddr)
      `OFS_PIPE_MODE:      rdMux = pipeMode;
      `OFS_DATA_PATH:      rdMux = dataPath;
      `OFS_CPU_GATE:       rdMux = {31'h0000_0000, clockGates[0]};
      `OFS_SENSOR_GATE:    rdMux = {31'h0000_0000, clockGates[1]};
      `OFS_MEMORY_GATE:    rdMux = {31'h0000_0000, clockGates[2]};
      `OFS_TBL_MODE:       rdMux = tblMode;
      `OFS_TBL_ADDR:       rdMux = tblAddr;
      `OFS_TBL_WDATA:      rdMux = tblWdata;
      `OFS_TBL_RDATA:      rdMux = tblRdata;
      `OFS_EVENT_ENABLE:   rdMux = {26'h000_0000, eventEnable};
      `OFS_RESIZER_MODE:   rdMux = resizerMode;
      `OFS_HIST_MODE:      rdMux = histMode;
      `OFS_HIST_SOURCE:    rdMux = histSource;
      `OFS_RSZ_A_INTERVAL: rdMux = 32'(pendInterval[0]);
      `OFS_RSZ_B_INTERVAL: rdMux = 32'(pendInterval[1]);
      `OFS_RSZ_A_PHASE:    rdMux = 32'(lastPhase[0]);
      `OFS_RSZ_A_LINES:    rdMux = 32'(lineTotal[0]);
      `OFS_RSZ_A_PTR:      rdMux = 32'(linePtr[0]);
      `OFS_RSZ_B_PHASE:    rdMux = 32'(lastPhase[1]);
      `OFS_RSZ_B_LINES:    rdMux = 32'(lineTotal[1]);
      `OFS_RSZ_B_PTR:      rdMux = 32'(linePtr[1]);
      `OFS_OVERHEAD:       rdMux = {20'h0_0000, botOvh, topOvh, latOvh};
      default: begin
        // Shadow window or unmapped: unmapped reads as zero
        for (int i = 0; i < NUM_SHADOW; i++) begin
          if (link.regAddr == 8'(`OFS_SHADOW_BASE + 4 * i)) begin
            rdMux = pendShadow[i];
          end
        end
      end
    endcase
  end
  assign link.regRdata = rdMux;

  // Immediate-effect registers take the write at once, busy or not
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pipeMode    <= 32'h0000_0000;
      dataPath    <= 32'h0000_0000;
      clockGates  <= 3'h0;
      tblMode     <= 32'h0000_0000;
      tblAddr     <= 32'h0000_0000;
      tblWdata    <= 32'h0000_0000;
      tblWrStrobe <= 1'b0;
      eventEnable <= `RST_EVENT_ENABLE;
      resizerMode <= 32'h0000_0000;
      histMode    <= 32'h0000_0000;
      histSource  <= 32'h0000_0000;
    end else if (clkEn) begin
      if (wrPipeMode) pipeMode <= link.regWdata;
      if (wrDataPath) dataPath <= link.regWdata;
      for (int g = 0; g < 3; g++) begin
        if (wrGate[g]) clockGates[g] <= link.regWdata[0];
      end
      if (wrTblMode)  tblMode  <= link.regWdata;
      if (wrTblAddr)  tblAddr  <= link.regWdata;
      if (wrTblWdata) tblWdata <= link.regWdata;
      tblWrStrobe <= wrTblWdata;                            // Table write kicks the memory access
      if (wrEventEn)  eventEnable <= link.regWdata[5:0];
      if (wrRszMode)  resizerMode <= link.regWdata;
      if (wrHistMode) histMode    <= link.regWdata;
      if (wrHistSrc)  histSource  <= link.regWdata;
    end
  end

  // Shadowed words: pending copy on write, whole set goes active in one cycle at frame start
  for (genvar s = 0; s < NUM_SHADOW; s++) begin : g_shadow
    wire wrThis = link.regWr && link.regAddr == 8'(`OFS_SHADOW_BASE + 4 * s);
    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
        pendShadow[s]   <= 32'h0000_0000;
        activeShadow[s] <= 32'h0000_0000;
      end else if (clkEn) begin
        if (wrThis) pendShadow[s] <= link.regWdata;
        // A write in the start cycle itself lands next frame only
        if (frameStart) activeShadow[s] <= pendShadow[s];
      end
    end
  end

  // Per-resizer interval, phase, line count and buffer pointer
  for (genvar r = 0; r < 2; r++) begin : g_rsz
    wire wrIntv = link.regWr && link.regAddr == (r == 0 ? `OFS_RSZ_A_INTERVAL : `OFS_RSZ_B_INTERVAL);
    wire [CNT_W-1:0] phaseIn = (r == 0) ? rszPhaseA : rszPhaseB;
    wire hitInterval = rszLineDone[r] && (intervalCnt[r] + 1'b1 >= actInterval[r]);
    assign rawEvent[`EV_RSZ_A_INTERVAL + r] = hitInterval;
    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
        pendInterval[r] <= CNT_W'(`RST_INTERVAL);
        actInterval[r]  <= CNT_W'(`RST_INTERVAL);
        intervalCnt[r]  <= '0;
        lineCnt[r]      <= '0;
        lastPhase[r]    <= '0;
        lineTotal[r]    <= '0;
        linePtr[r]      <= '0;
      end else if (clkEn) begin
        if (wrIntv) pendInterval[r] <= link.regWdata[CNT_W-1:0];
        if (frameStart) begin
          actInterval[r] <= pendInterval[r];
          intervalCnt[r] <= '0;
          linePtr[r]     <= pendShadow[3][CNT_W-1:0];   // Pointer restarts from the new base
        end else if (rszLineDone[r]) begin
          intervalCnt[r] <= hitInterval ? '0 : intervalCnt[r] + 1'b1;
          linePtr[r]     <= linePtr[r] + 1'b1;
        end
        if (rszLineDone[r]) lastPhase[r] <= phaseIn;
        if (rszPassDone[r]) begin
          lineTotal[r] <= lineCnt[r] + CNT_W'(rszLineDone[r]);
          lineCnt[r]   <= '0;
        end else if (rszLineDone[r]) begin
          lineCnt[r] <= lineCnt[r] + 1'b1;
        end
      end
    end
  end

  // Run state, event pulses and boundary mask
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pipeRunning  <= 1'b0;
      startSeen    <= 1'b0;
      eventReg     <= 6'h00;
      boundaryMask <= 1'b0;
    end else if (clkEn) begin
      startSeen    <= frameStart && pipeRunning;
      eventReg     <= rawEvent & eventEnable;
      boundaryMask <= next_boundaryMask;
      if (!pipeRunning && pipeMode[`BIT_PIPE_ENABLE] && frameStart) begin
        pipeRunning <= 1'b1;
      end else if (pipeRunning && frameEnd) begin
        // Stop is only looked at when the frame closes
        pipeRunning <= pipeMode[`BIT_PIPE_ENABLE] && pipeMode[`BIT_PIPE_CONT];
      end
    end
  end

endmodule

// ---- image_pipe_event_shadow_ctrl_assertions.sv ----
// Concurrent checks on the pipe link and on the device's event causes
`timescale 1ns/10ps
module image_pipe_event_shadow_ctrl_assertions
  import image_pipe_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire reg_addr_t   regAddr,
  input wire word_t       regWdata,
  input wire logic        regWr,
  input wire logic        regRd,
  input wire word_t       regRdata,
  input wire event_vec_t  events,
  input wire logic        frameStart,
  input wire logic        frameEnd,
  input wire logic        pipeFlushed,
  input wire logic        histDone,
  input wire logic        memWriteDone,
  input wire logic        pipeRunning,
  input wire logic [31:0] pipeMode
);
  event_vec_t en;   // Mirror of the event enable register
  word_t      ivA;  // Last value written to the resizer A interval
  wire        wrEn  = regWr && (regAddr == 8'h24);  // Event enable write
  wire        wrIvA = regWr && (regAddr == 8'h34);  // Interval A write

  // Mirror only what the link carries, so the checker never peeks inside
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      en  <= 6'h00;
      ivA <= 32'h0000_0010;
    end else begin
      en  <= wrEn ? regWdata[5:0] : en;
      ivA <= wrIvA ? regWdata : ivA;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // A running frame start, with its event enabled
  sequence s_running_frame;
    frameStart && pipeRunning && en[5];
  endsequence

  a_update_ready: assert property (s_running_frame |-> ##2 events[5])
    else $error("update ready event missing");
  a_update_cause: assert property (events[5] |-> $past(frameStart, 2))
    else $error("update ready without frame start");
  a_frame_done: assert property ((pipeFlushed || histDone) && en[0] |=> events[0])
    else $error("frame done event missing");
  a_frame_cause: assert property (events[0] |-> $past(pipeFlushed) || $past(histDone))
    else $error("frame done without cause");
  a_mem_done: assert property (memWriteDone && en[1] |=> events[1])
    else $error("memory write done event missing");
  a_event_gated: assert property (events != 6'h00 |-> (events & ~$past(en)) == 6'h00)
    else $error("disabled event raised");
  a_shadow_read: assert property (regRd && regAddr == 8'h34 |-> regRdata == ivA)
    else $error("shadow read not latest write");
  a_mode_immediate: assert property (regWr && regAddr == 8'h00 |=> pipeMode == $past(regWdata))
    else $error("pipe mode not applied at once");
  a_oneshot_stop: assert property (frameEnd && pipeRunning && !pipeMode[1] |=> !pipeRunning)
    else $error("one shot pipe kept running");
endmodule

// ---- image_pipe_event_shadow_ctrl_tb.sv ----
// Self-checking bench: device and host ends joined over the pipe link
`timescale 1ns/10ps
module image_pipe_event_shadow_ctrl_tb;
  import image_pipe_pkg::*;
  logic        ref_clk;            // 200 MHz clock
  logic        rst_n;              // Active-low reset
  logic [8:0]  cz;                 // Cause pulses: start,end,flush,hist,mem,lineA,lineB,passA,passB
  logic [8:0]  cpuAddr;            // Host register port
  logic [31:0] cpuWdata;
  logic        cpuWr;
  logic        cpuRd;
  logic [31:0] cpuRdata;
  logic [15:0] phA;                // Resizer A line phase
  logic [15:0] pix;                // Pixel column and line row under test
  logic        bMask;              // Boundary mask seen from the device
  logic        pipeRunning;
  logic [31:0] pipeMode;
  logic [31:0] activeShadow [4];
  logic [31:0] seed;               // Random source state
  logic [5:0]  ev;                 // Enable pattern under test
  int          mismatches;
  int          checks_done;
  int          n;                  // Bounded wait counter
  int          phq[$];             // Model: phases of lines in the current pass
  image_pipe_if link ();

  image_pipe_event_shadow_ctrl image_pipe_event_shadow_ctrl_i (
    .ref_clk(ref_clk), .rst_n(rst_n), .clkEn(1'b1), .link(link.device),
    .frameStart(cz[0]), .frameEnd(cz[1]), .pipeFlushed(cz[2]), .histDone(cz[3]),
    .memWriteDone(cz[4]), .rszLineDone(cz[6:5]), .rszPassDone(cz[8:7]), .rszPhaseA(phA),
    .rszPhaseB(seed[31:16]), .pixCol(pix), .lineRow(pix), .tblRdata(32'h0000_0000),
    .pipeRunning(pipeRunning), .boundaryMask(bMask), .pipeMode(pipeMode), .dataPath(), .clockGates(),
    .tblMode(), .tblAddr(), .tblWdata(), .tblWrStrobe(), .resizerMode(), .histMode(),
    .histSource(), .activeShadow(activeShadow));
  image_pipe_host_end image_pipe_host_end_i (
    .ref_clk(ref_clk), .rst_n(rst_n), .clkEn(1'b1), .link(link.host), .cpuAddr(cpuAddr),
    .cpuWdata(cpuWdata), .cpuWr(cpuWr), .cpuRd(cpuRd), .cpuRdata(cpuRdata), .eventPending());
  image_pipe_event_shadow_ctrl_assertions image_pipe_event_shadow_ctrl_assertions_i (
    .ref_clk(ref_clk), .rst_n(rst_n), .regAddr(link.regAddr), .regWdata(link.regWdata),
    .regWr(link.regWr), .regRd(link.regRd), .regRdata(link.regRdata), .events(link.events),
    .frameStart(cz[0]), .frameEnd(cz[1]), .pipeFlushed(cz[2]), .histDone(cz[3]),
    .memWriteDone(cz[4]), .pipeRunning(pipeRunning), .pipeMode(pipeMode));

  // Free-running clock
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // Shift-register random source
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Compare and count; case inequality so unknowns never pass
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One-cycle write; leaves the edge's time step so a next call never reassigns the strobe in it
  task automatic wr(input logic [8:0] a, input logic [31:0] d);
    cpuAddr  <= a;
    cpuWdata <= d;
    cpuWr    <= 1'b1;
    @(posedge ref_clk);
    cpuWr <= 1'b0;
    #1;
  endtask

  // One-cycle read; data stands only in the following cycle
  task automatic rd(input logic [8:0] a, input logic [31:0] exp);
    cpuAddr <= a;
    cpuRd   <= 1'b1;
    @(posedge ref_clk);
    cpuRd <= 1'b0;
    #1;
    chk(cpuRdata, exp);
  endtask

  // Pulse causes for one cycle, then compare the events d edges after they were raised
  task automatic pulse(input logic [8:0] c, input int d, input logic [5:0] exp);
    cz <= c;
    @(posedge ref_clk);
    cz <= 9'h000;
    repeat (d - 1) @(posedge ref_clk);
    #1;
    chk({26'h0, link.events}, {26'h0, exp});
  endtask

  // Counts, then the verdict, then the end of the run
  task automatic print_verdict();
    $display("mismatches %0d checks_done %0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    rst_n = 1'b0;
    cz = 9'h000;
    cpuAddr = 9'h000;
    cpuWdata = 32'h0000_0000;
    cpuWr = 1'b0;
    cpuRd = 1'b0;
    phA = 16'h0000;
    pix = 16'h0000;
    seed = 32'h0000_003e;
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    // Reset values, overhead figures and an unmapped place
    rd(9'h124, 32'h0000_0000);
    rd(9'h134, 32'h0000_0010);
    rd(9'h168, 32'h0000_0878);
    rd(9'h1fc, 32'h0000_0000);
    // Frame-done and memory-write-done enable bits each gate their own event only
    for (int k = 0; k < 4; k++) begin
      ev = (k == 0) ? 6'h00 : (k == 1) ? 6'h3f : seed[5:0];
      seed = lfsr(seed);
      wr(9'h124, {26'h0, ev});
      pulse(9'h010, 1, ev & 6'h02);
      pulse(9'h004, 1, ev & 6'h01);
      pulse(9'h008, 1, ev & 6'h01);
    end
    wr(9'h124, 32'h0000_003f);
    // Immediate group acts at once: enable plus continuous mode
    wr(9'h100, 32'h0000_0003);
    #1;
    chk(pipeMode, 32'h0000_0003);
    // Shadowed writes wait for the frame start, reads show them early
    wr(9'h134, 32'h0000_0003);
    wr(9'h138, 32'h0000_0002);
    wr(9'h13c, 32'h0000_0001);
    rd(9'h134, 32'h0000_0003);
    rd(9'h168, 32'h0000_0878);
    pulse(9'h001, 2, 6'h00);
    chk(activeShadow[0], 32'h0000_0001);
    rd(9'h168, 32'h0000_0879);
    // Interval events and pass status against the model queue
    for (int k = 1; k <= 3; k++) begin
      phA <= seed[15:0];
      phq.push_back(int'(seed[15:0]));
      seed = lfsr(seed);
      pulse(9'h020, 1, (k == 3) ? 6'h04 : 6'h00);
    end
    for (int k = 1; k <= 2; k++) pulse(9'h040, 1, (k == 2) ? 6'h08 : 6'h00);
    pulse(9'h080, 1, 6'h00);
    rd(9'h154, phq.size());
    rd(9'h150, phq[$]);
    rd(9'h158, 32'h0000_0003);
    // Host holds a shadow write until update ready
    wr(9'h004, 32'h0000_0038);
    wr(9'h008, 32'h0000_0007);
    rd(9'h138, 32'h0000_0002);
    pulse(9'h001, 2, 6'h20);
    n = 0;
    while (n < 20 && !(link.regWr && link.regAddr == 8'h38)) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    if (n == 20) begin
      mismatches++;
      $display("BAD %0t deferred write never sent", $time);
      print_verdict();
    end
    @(posedge ref_clk);
    rd(9'h138, 32'h0000_0007);
    // One-shot mode stops at the frame end
    wr(9'h100, 32'h0000_0001);
    pulse(9'h002, 1, 6'h10);
    chk({31'h0, pipeRunning}, 32'h0000_0000);
    // Division mode masks only the block border: 64 by 64 block, lateral 9, top 7, bottom 8
    wr(9'h140, 32'h0000_0040); // width leaves room for the overlap
    wr(9'h144, 32'h0000_0040);
    wr(9'h128, 32'h0000_0004);
    pulse(9'h001, 1, 6'h00);
    for (int k = 0; k < 2; k++) begin
      pix <= (k == 0) ? 16'h0020 : 16'h0003;
      @(posedge ref_clk);
      #1;
      chk({31'h0, bMask}, {31'h0, k == 1});
    end
    print_verdict();
  end
endmodule

// ---- image_pipe_host_end.sv ----
// Host end that services pipe events and defers shadow writes to the update-ready event
`timescale 1ns/10ps
`include "image_pipe_defs.svh"
module image_pipe_host_end
  import image_pipe_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        clkEn,
  image_pipe_if.host       link,
  input  wire logic [8:0]  cpuAddr,
  input  wire logic [31:0] cpuWdata,
  input  wire logic        cpuWr,
  input  wire logic        cpuRd,
  output logic [31:0]      cpuRdata,
  output logic             eventPending
);

  event_vec_t   eventStatus;   // Sticky copy of every event seen
  reg_addr_t    defAddr;       // Deferred shadow write address
  word_t        defData;       // Deferred shadow write data
  defer_state_t defState;      // Deferred write progress

  // Decode of the software port: bit 8 opens the device window
  wire devSel    = cpuAddr[`HOST_DEV_WINDOW];
  wire devAccess = devSel && (cpuWr || cpuRd);
  wire wrStatus  = !devSel && cpuWr && cpuAddr[7:0] == `OFS_HOST_STATUS;
  wire wrDefAddr = !devSel && cpuWr && cpuAddr[7:0] == `OFS_HOST_DEF_ADDR;
  wire wrDefData = !devSel && cpuWr && cpuAddr[7:0] == `OFS_HOST_DEF_DATA;
  wire readyEv   = link.events[`EV_UPDATE_READY];
  // Deferred write yields to a direct access so software never waits
  wire defIssue  = defState == DEF_ISSUE && !devAccess;

  // Link drive: direct access first, else the deferred write
  assign link.regAddr  = devAccess ? cpuAddr[7:0] : defAddr;
  assign link.regWdata = devAccess ? cpuWdata : defData;
  assign link.regWr    = (devSel && cpuWr) || defIssue;
  assign link.regRd    = devSel && cpuRd;

  // Local read mux
  word_t localRd;
  always_comb begin
    localRd = 32'h0000_0000;
    unique case (cpuAddr[7:0])
      `OFS_HOST_STATUS:    localRd = {26'h000_0000, eventStatus};
      `OFS_HOST_DEF_ADDR:  localRd = {24'h00_0000, defAddr};
      `OFS_HOST_DEF_DATA:  localRd = defData;
      `OFS_HOST_DEF_STATE: localRd = {30'h0000_0000, defState};
      default:             localRd = 32'h0000_0000;
    endcase
  end

  // Read data one cycle after the strobe; sticky status with set over clear
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cpuRdata     <= 32'h0000_0000;
      eventStatus  <= 6'h00;
      eventPending <= 1'b0;
    end else if (clkEn) begin
      if (cpuRd) cpuRdata <= devSel ? link.regRdata : localRd;
      // Write one clears; a new event in the same cycle stays set
      eventStatus  <= (eventStatus & ~(wrStatus ? cpuWdata[5:0] : 6'h00)) | link.events;
      eventPending <= |link.events || (|(eventStatus & ~(wrStatus ? cpuWdata[5:0] : 6'h00)));
    end
  end

  // Deferred write: held until the update-ready event, then sent once
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      defAddr  <= 8'h00;
      defData  <= 32'h0000_0000;
      defState <= DEF_IDLE;
    end else if (clkEn) begin
      if (wrDefAddr) defAddr <= cpuWdata[7:0];
      if (wrDefData) defData <= cpuWdata;
      unique case (defState)
        DEF_IDLE:  if (wrDefData) defState <= DEF_WAIT;
        DEF_WAIT:  if (readyEv) defState <= DEF_ISSUE;
        DEF_ISSUE: if (defIssue) defState <= DEF_IDLE;
        default:   defState <= DEF_IDLE;
      endcase
    end
  end

endmodule

// ---- image_pipe_if.sv ----
// Link between the image pipe registers/events and the host servicing it
`timescale 1ns/10ps
interface image_pipe_if;
  import image_pipe_pkg::*;
  reg_addr_t  regAddr;   // Register byte address
  word_t      regWdata;  // Write data
  logic       regWr;     // Write strobe
  logic       regRd;     // Read strobe
  word_t      regRdata;  // Read data, same cycle as the address
  event_vec_t events;    // One-cycle event pulses
  modport device (input regAddr, regWdata, regWr, regRd, output regRdata, events);
  modport host   (output regAddr, regWdata, regWr, regRd, input regRdata, events);
endinterface

// ---- image_pipe_pkg.sv ----
// Types shared by the image pipe device end and its servicing host end
package image_pipe_pkg;
  typedef logic [31:0] word_t;       // Register data word
  typedef logic [7:0]  reg_addr_t;   // Register byte address
  typedef logic [5:0]  event_vec_t;  // One bit per event line
  typedef enum logic [1:0] {DEF_IDLE, DEF_WAIT, DEF_ISSUE} defer_state_t;
endpackage
